// >>> inc/cms_consts.svh
// Offsets, field positions, reset values and timing counts of the mode sequencer
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH

`define CMS_ADDR_W 8
`define CMS_DATA_W 32

`define CMS_OFS_STATUS 8'h00
`define CMS_OFS_TEMP 8'h04
`define CMS_OFS_FIELD_X 8'h08
`define CMS_OFS_FIELD_Y 8'h0C
`define CMS_OFS_FIELD_Z 8'h10
`define CMS_OFS_MODE_SEL 8'h14
`define CMS_OFS_COND_X 8'h18
`define CMS_OFS_COND_Y 8'h1C
`define CMS_OFS_COND_Z 8'h20
`define CMS_OFS_NVM_BASE 8'h40
`define CMS_NVM_WORDS 8
`define CMS_NVM_IDX_W 3

`define CMS_STAT_DONE_BIT 0
`define CMS_STAT_MODE_LSB 1
`define CMS_MODE_LSB 0

`define CMS_MODE_MEASURE 2'h0
`define CMS_MODE_NVM 2'h2
`define CMS_MODE_POWER_DOWN 2'h3

`define CMS_RESULT_RST 8'h00
`define CMS_COND_RST 8'h00
`define CMS_NVM_RST 64'h0000_0000_0000_0000

`define CMS_RESP_OKAY 2'h0
`define CMS_RESP_SLVERR 2'h2

`define CMS_CLK_PERIOD_PS 10000
`define CMS_TSM_PS 64'd12560000000
`define CMS_TSM_CYCLES (`CMS_TSM_PS / `CMS_CLK_PERIOD_PS)

`endif

// >>> inc/cms_pkg.sv
// Types shared by the mode sequencer, its checker, host model and bench
package cms_pkg;

    typedef logic [7:0] cms_addr_t;
    typedef logic [31:0] cms_data_t;
    typedef logic [7:0] cms_byte_t;

    typedef enum logic [2:0] {
        ST_POWER_DOWN = 3'b000,
        ST_MEAS_TEMP = 3'b001,
        ST_MEAS_X = 3'b010,
        ST_MEAS_Y = 3'b011,
        ST_MEAS_Z = 3'b100,
        ST_NVM = 3'b101
    } cms_state_e;

    typedef struct packed {
        cms_addr_t awaddr;
        logic awvalid;
        cms_data_t wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        cms_addr_t araddr;
        logic arvalid;
        logic rready;
    } cms_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        cms_data_t rdata;
        logic [1:0] rresp;
        logic rvalid;
    } cms_axil_rsp_s;

    typedef struct packed {
        cms_byte_t temp;
        cms_byte_t x;
        cms_byte_t y;
        cms_byte_t z;
    } cms_sample_s;

endpackage

// >>> logic/cms_cal_mem.sv
// Small calibration memory with registered read data
`timescale 1ns/1ps
`include "cms_consts.svh"

module cms_cal_mem #(
    parameter int WORDS = `CMS_NVM_WORDS,
    parameter int IDX_W = `CMS_NVM_IDX_W,
    parameter logic [8*`CMS_NVM_WORDS-1:0] FACTORY = `CMS_NVM_RST
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [IDX_W-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [IDX_W-1:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [WORDS];

    // Factory image reloads at reset; stands in for the nonvolatile cells
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < WORDS; i++) begin
            if (!i_rst_n) begin
                mem[i] <= FACTORY[8*i +: 8];
            end else if (i_we && (i_waddr == IDX_W'(i))) begin
                mem[i] <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule // cms_cal_mem

// >>> logic/cms_mode_sequencer.sv
// Operating-mode controller and measurement sequencer with AXI4-Lite registers
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cms_consts.svh"

module cms_mode_sequencer
    import cms_pkg::*;
#(
    parameter int MEAS_CYCLES = int'(`CMS_TSM_CYCLES),
    parameter logic [8*`CMS_NVM_WORDS-1:0] NVM_FACTORY = `CMS_NVM_RST
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire cms_pkg::cms_axil_req_s I_AXIL_REQ,
    output cms_pkg::cms_axil_rsp_s O_AXIL_RSP,
    input wire cms_pkg::cms_sample_s I_SENSOR_SAMPLE,
    output logic O_MEAS_DONE,
    output logic O_ANALOG_PWR_EN,
    output cms_pkg::cms_byte_t O_COND_X,
    output cms_pkg::cms_byte_t O_COND_Y,
    output cms_pkg::cms_byte_t O_COND_Z
);
    import cms_pkg::*;

    // Four equal phases; the last cycle of each phase stores its sample
    localparam int PHASE_LEN = (MEAS_CYCLES / 4 < 1) ? 1 : MEAS_CYCLES / 4;
    localparam int CNT_W = $clog2(PHASE_LEN + 1);
    localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(PHASE_LEN - 1);
    localparam int NVM_W = `CMS_NVM_IDX_W;

    function automatic logic word_hit(input cms_addr_t a, input cms_addr_t ofs);
        return a[7:2] == ofs[7:2];
    endfunction

    function automatic logic is_result(input cms_addr_t a);
        return word_hit(a, `CMS_OFS_TEMP) || word_hit(a, `CMS_OFS_FIELD_X)
            || word_hit(a, `CMS_OFS_FIELD_Y) || word_hit(a, `CMS_OFS_FIELD_Z);
    endfunction

    function automatic logic is_nvm(input cms_addr_t a);
        return (a >= `CMS_OFS_NVM_BASE)
            && (a < `CMS_ADDR_W'(`CMS_OFS_NVM_BASE + 4 * `CMS_NVM_WORDS));
    endfunction

    function automatic logic [NVM_W-1:0] nvm_index(input cms_addr_t a);
        return a[NVM_W+1:2];
    endfunction

    function automatic logic is_mapped(input cms_addr_t a);
        return word_hit(a, `CMS_OFS_STATUS) || is_result(a)
            || word_hit(a, `CMS_OFS_MODE_SEL) || word_hit(a, `CMS_OFS_COND_X)
            || word_hit(a, `CMS_OFS_COND_Y) || word_hit(a, `CMS_OFS_COND_Z) || is_nvm(a);
    endfunction

    cms_state_e state;
    logic [CNT_W-1:0] phase_cnt;
    logic phase_end;
    logic measuring;
    logic done;
    cms_byte_t temp_result;
    cms_byte_t field_x_result;
    cms_byte_t field_y_result;
    cms_byte_t field_z_result;
    cms_byte_t cond_x;
    cms_byte_t cond_y;
    cms_byte_t cond_z;
    cms_sample_s sample_meta;
    cms_sample_s sample;

    logic aw_held;
    cms_addr_t aw_addr;
    logic w_held;
    cms_data_t w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic do_write;
    logic low_lane;

    logic r_pend;
    cms_addr_t r_addr;
    logic rvalid;
    cms_data_t rdata;
    logic [1:0] rresp;
    logic rd_take;
    cms_data_t next_rdata;

    logic mode_wr;
    logic [1:0] mode_code;
    logic enter_meas;
    logic enter_nvm;
    logic nvm_we;
    cms_byte_t nvm_rdata;

    // Sensor front-end levels come from the analog side: two stages first
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            sample_meta <= '0;
            sample <= '0;
        end else begin
            sample_meta <= I_SENSOR_SAMPLE;
            sample <= sample_meta;
        end
    end

    // Write channel: address and data taken in either order, then answered
    always_comb begin
        do_write = aw_held && w_held && !bvalid;
        low_lane = w_strb[0];
        mode_wr = do_write && low_lane && word_hit(aw_addr, `CMS_OFS_MODE_SEL);
        mode_code = w_data[`CMS_MODE_LSB +: 2];
        nvm_we = do_write && low_lane && is_nvm(aw_addr) && (state == ST_NVM);
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (I_AXIL_REQ.awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= I_AXIL_REQ.awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (I_AXIL_REQ.wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= I_AXIL_REQ.wdata;
            w_strb <= I_AXIL_REQ.wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            bvalid <= 1'b0;
            bresp <= `CMS_RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= is_mapped(aw_addr) ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
        end else if (bvalid && I_AXIL_REQ.bready) begin
            bvalid <= 1'b0;
        end
    end

    // Conditions are writable in any mode; the host keeps them to power-down
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            cond_x <= `CMS_COND_RST;
            cond_y <= `CMS_COND_RST;
            cond_z <= `CMS_COND_RST;
        end else if (do_write && low_lane) begin
            if (word_hit(aw_addr, `CMS_OFS_COND_X)) begin
                cond_x <= w_data[7:0];
            end
            if (word_hit(aw_addr, `CMS_OFS_COND_Y)) begin
                cond_y <= w_data[7:0];
            end
            if (word_hit(aw_addr, `CMS_OFS_COND_Z)) begin
                cond_z <= w_data[7:0];
            end
        end
    end

    // Mode sequencing
    always_comb begin
        measuring = (state == ST_MEAS_TEMP) || (state == ST_MEAS_X)
            || (state == ST_MEAS_Y) || (state == ST_MEAS_Z);
        phase_end = measuring && (phase_cnt == PHASE_LAST);
        enter_meas = (state == ST_POWER_DOWN) && mode_wr
            && (mode_code == `CMS_MODE_MEASURE) && !done;
        enter_nvm = (state == ST_POWER_DOWN) && mode_wr && (mode_code == `CMS_MODE_NVM);
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            state <= ST_POWER_DOWN;
        end else begin
            unique case (state)
                ST_POWER_DOWN: begin
                    if (enter_meas) begin
                        state <= ST_MEAS_TEMP;
                    end else if (enter_nvm) begin
                        state <= ST_NVM;
                    end
                end
                ST_MEAS_TEMP: begin
                    if (phase_end) begin
                        state <= ST_MEAS_X;
                    end
                end
                ST_MEAS_X: begin
                    if (phase_end) begin
                        state <= ST_MEAS_Y;
                    end
                end
                ST_MEAS_Y: begin
                    if (phase_end) begin
                        state <= ST_MEAS_Z;
                    end
                end
                ST_MEAS_Z: begin
                    if (phase_end) begin
                        state <= ST_POWER_DOWN;
                    end
                end
                ST_NVM: begin
                    // Any other code here is dropped: the way out is power-down only
                    if (mode_wr && (mode_code == `CMS_MODE_POWER_DOWN)) begin
                        state <= ST_POWER_DOWN;
                    end
                end
                default: begin
                    state <= ST_POWER_DOWN;
                end
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            phase_cnt <= '0;
        end else if (!measuring || phase_end) begin
            phase_cnt <= '0;
        end else begin
            phase_cnt <= phase_cnt + 1'b1;
        end
    end

    // Analog power follows the mode; off whenever idle in power-down
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            O_ANALOG_PWR_EN <= 1'b0;
        end else begin
            O_ANALOG_PWR_EN <= enter_meas || enter_nvm
                || (measuring && !(state == ST_MEAS_Z && phase_end))
                || (state == ST_NVM && !(mode_wr && mode_code == `CMS_MODE_POWER_DOWN));
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            temp_result <= `CMS_RESULT_RST;
        end else if ((state == ST_MEAS_TEMP) && phase_end) begin
            temp_result <= sample.temp;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            field_x_result <= `CMS_RESULT_RST;
            field_y_result <= `CMS_RESULT_RST;
            field_z_result <= `CMS_RESULT_RST;
        end else if (enter_meas || enter_nvm) begin
            field_x_result <= `CMS_RESULT_RST;
            field_y_result <= `CMS_RESULT_RST;
            field_z_result <= `CMS_RESULT_RST;
        end else if (phase_end) begin
            if (state == ST_MEAS_X) begin
                field_x_result <= sample.x;
            end
            if (state == ST_MEAS_Y) begin
                field_y_result <= sample.y;
            end
            if (state == ST_MEAS_Z) begin
                field_z_result <= sample.z;
            end
        end
    end

    // One flag drives both pin and status bit, so they always fall together
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            done <= 1'b0;
        end else if ((state == ST_MEAS_Z) && phase_end) begin
            done <= 1'b1;
        end else if (rd_take && is_result(I_AXIL_REQ.araddr)) begin
            done <= 1'b0;
        end
    end

    // Read channel: one read in flight; data two cycles after the address
    always_comb begin
        rd_take = I_AXIL_REQ.arvalid && !r_pend && !rvalid;
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            r_pend <= 1'b0;
            r_addr <= '0;
        end else begin
            r_pend <= rd_take;
            if (rd_take) begin
                r_addr <= I_AXIL_REQ.araddr;
            end
        end
    end

    always_comb begin
        next_rdata = '0;
        if (word_hit(r_addr, `CMS_OFS_STATUS)) begin
            next_rdata[`CMS_STAT_DONE_BIT] = done;
            next_rdata[`CMS_STAT_MODE_LSB +: 3] = state;
        end else if (word_hit(r_addr, `CMS_OFS_TEMP)) begin
            next_rdata[7:0] = temp_result;
        end else if (word_hit(r_addr, `CMS_OFS_FIELD_X)) begin
            next_rdata[7:0] = field_x_result;
        end else if (word_hit(r_addr, `CMS_OFS_FIELD_Y)) begin
            next_rdata[7:0] = field_y_result;
        end else if (word_hit(r_addr, `CMS_OFS_FIELD_Z)) begin
            next_rdata[7:0] = field_z_result;
        end else if (word_hit(r_addr, `CMS_OFS_COND_X)) begin
            next_rdata[7:0] = cond_x;
        end else if (word_hit(r_addr, `CMS_OFS_COND_Y)) begin
            next_rdata[7:0] = cond_y;
        end else if (word_hit(r_addr, `CMS_OFS_COND_Z)) begin
            next_rdata[7:0] = cond_z;
        end else if (is_nvm(r_addr) && (state == ST_NVM)) begin
            // Memory is unpowered outside its access mode and reads as zero
            next_rdata[7:0] = nvm_rdata;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `CMS_RESP_OKAY;
        end else if (r_pend) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= is_mapped(r_addr) ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
        end else if (rvalid && I_AXIL_REQ.rready) begin
            rvalid <= 1'b0;
        end
    end

    // Writes land only in access mode; normal software never issues them
    cms_cal_mem #(
        .WORDS(`CMS_NVM_WORDS),
        .IDX_W(NVM_W),
        .FACTORY(NVM_FACTORY)
    ) u_cal_mem (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_we(nvm_we),
        .i_waddr(nvm_index(aw_addr)),
        .i_wdata(w_data[7:0]),
        .i_raddr(nvm_index(I_AXIL_REQ.araddr)),
        .o_rdata(nvm_rdata)
    );

    always_comb begin
        O_AXIL_RSP.awready = !aw_held;
        O_AXIL_RSP.wready = !w_held;
        O_AXIL_RSP.bvalid = bvalid;
        O_AXIL_RSP.bresp = bresp;
        O_AXIL_RSP.arready = !r_pend && !rvalid;
        O_AXIL_RSP.rvalid = rvalid;
        O_AXIL_RSP.rdata = rdata;
        O_AXIL_RSP.rresp = rresp;
    end

    assign O_MEAS_DONE = done;
    assign O_COND_X = cond_x;
    assign O_COND_Y = cond_y;
    assign O_COND_Z = cond_z;
endmodule // cms_mode_sequencer

// >>> sim/cms_mode_sequencer_chk.sv
// Port assertions for the mode sequencer
`timescale 1ns/1ps
module cms_mode_sequencer_chk
    import cms_pkg::*;
#(
    parameter int MEAS_CYCLES = 40
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire cms_pkg::cms_axil_req_s I_AXIL_REQ,
    input wire cms_pkg::cms_axil_rsp_s O_AXIL_RSP,
    input wire cms_pkg::cms_sample_s I_SENSOR_SAMPLE,
    input wire logic O_MEAS_DONE,
    input wire logic O_ANALOG_PWR_EN,
    input wire cms_pkg::cms_byte_t O_COND_X,
    input wire cms_pkg::cms_byte_t O_COND_Y,
    input wire cms_pkg::cms_byte_t O_COND_Z
);
    logic ar_hs;
    logic res_addr;
    logic wr_hs;
    int pwr_cnt;
    assign ar_hs = I_AXIL_REQ.arvalid && O_AXIL_RSP.arready;
    assign res_addr = I_AXIL_REQ.araddr inside {8'h04, 8'h08, 8'h0C, 8'h10};
    assign wr_hs = I_AXIL_REQ.awvalid && O_AXIL_RSP.awready && I_AXIL_REQ.wvalid
        && O_AXIL_RSP.wready;
    // Counts powered cycles so the sequence length can be judged at its end
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N || !O_ANALOG_PWR_EN) pwr_cnt <= 0;
        else pwr_cnt <= pwr_cnt + 1;
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence s_rd_answer;
        ##2 O_AXIL_RSP.rvalid && O_AXIL_RSP.rdata[31:8] == 24'h000000;
    endsequence
    sequence s_meas_end;
        $rose(O_MEAS_DONE) ##0 $fell(O_ANALOG_PWR_EN);
    endsequence
    a_reset_power_down: assert property (disable iff (1'b0)
        !I_RST_N |=> !O_MEAS_DONE && !O_ANALOG_PWR_EN) else $error("reset left power or done on");
    a_done_rd_clear: assert property (ar_hs && res_addr && O_MEAS_DONE |=> !O_MEAS_DONE)
        else $error("result read did not clear done");
    a_done_rd_keep: assert property (ar_hs && !res_addr && O_MEAS_DONE |=> O_MEAS_DONE)
        else $error("non-result read cleared done");
    a_done_with_pd: assert property ($rose(O_MEAS_DONE) |-> s_meas_end)
        else $error("done rose without return to power-down");
    a_meas_length: assert property ($rose(O_MEAS_DONE) |-> pwr_cnt == MEAS_CYCLES)
        else $error("measurement length wrong");
    a_read_answer: assert property (ar_hs |-> s_rd_answer)
        else $error("read answer late or upper bits set");
    // Both halves held at the handshake edge, answered one edge later
    a_write_answer: assert property (wr_hs |-> ##2 O_AXIL_RSP.bvalid)
        else $error("write response missing");
    a_cond_stable: assert property ($changed({O_COND_X, O_COND_Y, O_COND_Z}) &&
        $past(I_RST_N) |-> O_AXIL_RSP.bvalid) else $error("condition changed without write");
endmodule // cms_mode_sequencer_chk
bind cms_mode_sequencer cms_mode_sequencer_chk #(.MEAS_CYCLES(MEAS_CYCLES)) chk_u (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_AXIL_REQ(I_AXIL_REQ),
    .O_AXIL_RSP(O_AXIL_RSP), .I_SENSOR_SAMPLE(I_SENSOR_SAMPLE), .O_MEAS_DONE(O_MEAS_DONE),
    .O_ANALOG_PWR_EN(O_ANALOG_PWR_EN), .O_COND_X(O_COND_X), .O_COND_Y(O_COND_Y),
    .O_COND_Z(O_COND_Z));

// >>> sim/cms_host_model.sv
// Host processor model: register bus master of the mode sequencer
`timescale 1ns/1ps
module cms_host_model
    import cms_pkg::*;
(
    input wire logic i_clk,
    input wire cms_pkg::cms_axil_rsp_s i_rsp,
    output cms_pkg::cms_axil_req_s o_req
);
    // Response ready held high: every answer is taken the edge it shows
    initial begin
        o_req = '0;
        o_req.bready = 1'b1;
        o_req.rready = 1'b1;
    end
    task automatic wr(input cms_addr_t a, input cms_data_t d, output logic [1:0] r);
        logic aw_d;
        logic w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        o_req.awaddr <= a;
        o_req.wdata <= d;
        o_req.wstrb <= 4'hF;
        o_req.awvalid <= 1'b1;
        o_req.wvalid <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge i_clk);
            if (!aw_d && i_rsp.awready) begin
                aw_d = 1'b1;
                o_req.awvalid <= 1'b0;
            end
            if (!w_d && i_rsp.wready) begin
                w_d = 1'b1;
                o_req.wvalid <= 1'b0;
            end
        end
        do @(posedge i_clk); while (!i_rsp.bvalid);
        r = i_rsp.bresp;
    endtask
    task automatic rd(input cms_addr_t a, output cms_data_t d, output logic [1:0] r);
        o_req.araddr <= a;
        o_req.arvalid <= 1'b1;
        do @(posedge i_clk); while (!i_rsp.arready);
        o_req.arvalid <= 1'b0;
        do @(posedge i_clk); while (!i_rsp.rvalid);
        d = i_rsp.rdata;
        r = i_rsp.rresp;
    endtask
    // Polls the status word until the finished flag shows, for at most 40 reads
    task automatic wait_done();
        cms_data_t s;
        logic [1:0] r;
        s = '0;
        for (int i = 0; i < 40 && s[0] !== 1'b1; i++) rd(8'h00, s, r);
    endtask
endmodule // cms_host_model

// >>> sim/compass_mode_sequencer_bench.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
`include "cms_consts.svh"
module compass_mode_sequencer_bench;
    import cms_pkg::*;
    localparam int MEAS = 40;
    localparam int TWAT = 10000;
    logic clk;
    logic rst_n;
    cms_axil_req_s req;
    cms_axil_rsp_s rsp;
    cms_sample_s smp;
    logic done;
    logic pwr;
    cms_byte_t cx;
    cms_byte_t cy;
    cms_byte_t cz;
    int err_count;
    int num_checks;
    cms_data_t rd;
    logic [1:0] rr;
    cms_host_model host_u (.i_clk(clk), .i_rsp(rsp), .o_req(req));
    cms_mode_sequencer #(.MEAS_CYCLES(MEAS)) dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_AXIL_REQ(req), .O_AXIL_RSP(rsp), .I_SENSOR_SAMPLE(smp), .O_MEAS_DONE(done),
        .O_ANALOG_PWR_EN(pwr), .O_COND_X(cx), .O_COND_Y(cy), .O_COND_Z(cz));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic rd_chk(input string what, input cms_addr_t a, input cms_data_t exp);
        host_u.rd(a, rd, rr);
        chk(what, rd, exp);
    endtask
    task automatic t_reset();
        rd_chk("status", `CMS_OFS_STATUS, 32'h00000000);
        chk("power", pwr, 32'h00000000);
        for (int i = 0; i < 4; i++) rd_chk("result", 8'h04 + 8'(4 * i), 32'h00000000);
        $display("test reset done");
    endtask
    task automatic t_cond();
        host_u.wr(`CMS_OFS_COND_X, 32'h0000005A, rr);
        host_u.wr(`CMS_OFS_COND_Y, 32'h000000A5, rr);
        host_u.wr(`CMS_OFS_COND_Z, 32'h0000003C, rr);
        chk("cond", {8'h00, cx, cy, cz}, 32'h005AA53C);
        $display("test cond done");
    endtask
    task automatic t_measure();
        smp <= 32'h78112233;
        repeat (TWAT) @(posedge clk);
        rd_chk("idle status", `CMS_OFS_STATUS, 32'h00000000);
        host_u.wr(`CMS_OFS_MODE_SEL, 32'h00000000, rr);
        @(posedge clk);
        chk("power on", pwr, 32'h00000001);
        rd_chk("temp phase", `CMS_OFS_STATUS, 32'h00000002);
        host_u.wait_done();
        chk("done pin", done, 32'h00000001);
        chk("power off", pwr, 32'h00000000);
        rd_chk("done status", `CMS_OFS_STATUS, 32'h00000001);
        rd_chk("cond read", `CMS_OFS_COND_X, 32'h0000005A);
        chk("done kept", done, 32'h00000001);
        host_u.wr(`CMS_OFS_MODE_SEL, 32'h00000000, rr);
        @(posedge clk);
        chk("no restart", pwr, 32'h00000000);
        rd_chk("temp", `CMS_OFS_TEMP, 32'h00000078);
        chk("done cleared", done, 32'h00000000);
        rd_chk("x", `CMS_OFS_FIELD_X, 32'h00000011);
        rd_chk("y", `CMS_OFS_FIELD_Y, 32'h00000022);
        rd_chk("z", `CMS_OFS_FIELD_Z, 32'h00000033);
        rd_chk("clear status", `CMS_OFS_STATUS, 32'h00000000);
        $display("test measure done");
    endtask
    task automatic t_nvm();
        repeat (TWAT) @(posedge clk);
        host_u.wr(`CMS_OFS_MODE_SEL, 32'h00000002, rr);
        @(posedge clk);
        chk("nvm power", pwr, 32'h00000001);
        rd_chk("nvm status", `CMS_OFS_STATUS, 32'h0000000A);
        host_u.wr(`CMS_OFS_MODE_SEL, 32'h00000000, rr);
        rd_chk("no jump", `CMS_OFS_STATUS, 32'h0000000A);
        rd_chk("x cleared", `CMS_OFS_FIELD_X, 32'h00000000);
        rd_chk("z cleared", `CMS_OFS_FIELD_Z, 32'h00000000);
        rd_chk("temp kept", `CMS_OFS_TEMP, 32'h00000078);
        rd_chk("cal byte", `CMS_OFS_NVM_BASE, 32'h00000000);
        host_u.wr(`CMS_OFS_MODE_SEL, 32'h00000003, rr);
        @(posedge clk);
        chk("pd power", pwr, 32'h00000000);
        rd_chk("pd status", `CMS_OFS_STATUS, 32'h00000000);
        chk("cond kept", {8'h00, cx, cy, cz}, 32'h005AA53C);
        $display("test nvm done");
    endtask
    task automatic t_bus();
        host_u.rd(8'hFC, rd, rr);
        chk("bad read resp", rr, 32'h00000002);
        host_u.wr(8'hFC, 32'h00000001, rr);
        chk("bad write resp", rr, 32'h00000002);
        rd_chk("mode reads zero", `CMS_OFS_MODE_SEL, 32'h00000000);
        do_reset();
        chk("cond reset", {8'h00, cx, cy, cz}, 32'h00000000);
        rd_chk("temp reset", `CMS_OFS_TEMP, 32'h00000000);
        $display("test bus done");
    endtask
    initial begin
        rst_n = 1'b0;
        smp = '0;
        err_count = 0;
        num_checks = 0;
        do_reset();
        t_reset();
        t_cond();
        t_measure();
        t_nvm();
        t_bus();
        end_of_test();
    end
    // Two idle waits dominate the run
    initial begin
        repeat (3 * TWAT) @(posedge clk);
        err_count++;
        end_of_test();
    end
endmodule // compass_mode_sequencer_bench
